// ### ospwc_timer.sv
`include "ospwc_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Pulse generation period is first compare plus one; high for second plus one.
// - One-shot only in free-run or edge-clear mode with single-pulse enable set.
// - Trigger bit or valid first-input edge clears counter and emits one pulse.
// - One-shot first-compare match raises match A event and inverts output.
// - One-shot second-compare match raises match B event and inverts output.
// - Pulse starts first compare plus one clocks after trigger; width is difference.
// - Two-input free-run: second input captures to A, first input to B.
// - One-input free-run: opposite edge captures to A, valid edge to B.
// - Edge-clear mode: valid edge captures to B then clears counter; opposite to A.
// - Counter wrap sets flag in mode register; software clears it after capture.
// - Reading the counter register returns the current count.
// - Free-run wraps from maximum to zero next count clock, setting the flag.
// - Match-clear mode restarts the counter when it equals the first compare.
module ospwc_timer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  // Pins
  input  wire logic        trig_capture_in_a,
  input  wire logic        capture_in_b,
  output logic             timer_out_pin,
  // Interrupt
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Edge select: 00 falling, 01 rising, 10 none, 11 both
  function automatic logic valid_edge(input logic [1:0] sel, input logic r, input logic f);
    unique case (sel)
      2'h0:    valid_edge = f;
      2'h1:    valid_edge = r;
      2'h2:    valid_edge = 1'b0;
      default: valid_edge = r | f;
    endcase
  endfunction

  // Opposite phase exists only when one single edge is selected
  function automatic logic opposite_edge(input logic [1:0] sel, input logic r, input logic f);
    unique case (sel)
      2'h0:    opposite_edge = r;
      2'h1:    opposite_edge = f;
      default: opposite_edge = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Inputs

  ospwc_pkg::ospwc_state_t s;
  ospwc_pkg::ospwc_state_t next_s;
  logic                    tick;
  logic                    a_rise;
  logic                    a_fall;
  logic                    b_rise;
  logic                    b_fall;

  ospwc_edge_detect u_edge_a (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (trig_capture_in_a),
    .rise    (a_rise),
    .fall    (a_fall)
  );

  ospwc_edge_detect u_edge_b (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (capture_in_b),
    .rise    (b_rise),
    .fall    (b_fall)
  );

  ospwc_prescaler u_prescaler (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .run           (s.mode != ospwc_pkg::OSPWC_MODE_STOP),
    .prescaler_sel (s.prescale),
    .tick          (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  logic        running;
  logic        shot_mode;
  logic        a_valid;
  logic        a_opposite;
  logic        b_valid;
  logic        cap_a;
  logic        cap_b;
  logic        match_a;
  logic        match_b;
  logic        wrap;
  logic        sw_trigger;
  logic        trigger;
  logic        edge_clear;
  logic        toggle;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;
  logic [15:0] rd_word;

  always_comb begin
    next_s     = s;
    running    = s.mode != ospwc_pkg::OSPWC_MODE_STOP;
    shot_mode  = s.out_ctrl[`OSPWC_SP_ENABLE_BIT]
                 && (s.mode == ospwc_pkg::OSPWC_MODE_FREE
                     || s.mode == ospwc_pkg::OSPWC_MODE_EDGE_CLR);
    a_valid    = running && valid_edge(s.edge_sel[1:0], a_rise, a_fall);
    a_opposite = running && opposite_edge(s.edge_sel[1:0], a_rise, a_fall);
    b_valid    = running && valid_edge(s.edge_sel[3:2], b_rise, b_fall);
    cap_a      = s.cap_ctrl[`OSPWC_CAP_A_EN_BIT];
    cap_b      = s.cap_ctrl[`OSPWC_CAP_B_EN_BIT];
    sw_trigger = wr_en && addr == `OSPWC_OFF_OUTPUT_CTRL
                 && wr_data[`OSPWC_SP_TRIGGER_BIT];
    // A trigger during a pulse restarts it; avoiding that is software's job
    trigger    = shot_mode && (sw_trigger || a_valid);
    edge_clear = s.mode == ospwc_pkg::OSPWC_MODE_EDGE_CLR && a_valid;

    // Compare matches are judged on the count clock with the count present
    match_a = running && tick && !cap_a && s.up_counter == s.cmp_a;
    match_b = running && tick && !cap_b && s.up_counter == s.cmp_b;
    wrap    = running && tick && s.mode != ospwc_pkg::OSPWC_MODE_MATCH_CLR
              && s.up_counter == `OSPWC_COUNT_MAX;

    // Counter
    if (!running) begin
      next_s.up_counter = `OSPWC_RESET_WORD;
    end else if (trigger || edge_clear) begin
      next_s.up_counter = `OSPWC_RESET_WORD;
    end else if (tick) begin
      if (s.mode == ospwc_pkg::OSPWC_MODE_MATCH_CLR && s.up_counter == s.cmp_a) begin
        next_s.up_counter = `OSPWC_RESET_WORD;
      end else begin
        next_s.up_counter = 16'(s.up_counter + 16'h0001);
      end
    end

    // Captures take the count of the cycle the edge was seen in
    if (cap_a) begin
      if (s.cap_ctrl[`OSPWC_CAP_A_SRC_BIT] ? a_opposite : b_valid) begin
        next_s.cmp_a = s.up_counter;
      end
    end
    if (cap_b && a_valid) begin
      next_s.cmp_b = s.up_counter;
    end

    // One-shot sequence and output inversion
    toggle = 1'b0;
    if (shot_mode) begin
      unique case (s.shot)
        ospwc_pkg::OSPWC_SHOT_IDLE: begin
          if (trigger) begin
            next_s.shot = ospwc_pkg::OSPWC_SHOT_WAIT_A;
          end
        end
        ospwc_pkg::OSPWC_SHOT_WAIT_A: begin
          if (trigger) begin
            next_s.shot = ospwc_pkg::OSPWC_SHOT_WAIT_A;
          end else if (match_a) begin
            toggle      = 1'b1;
            next_s.shot = ospwc_pkg::OSPWC_SHOT_WAIT_B;
          end
        end
        ospwc_pkg::OSPWC_SHOT_WAIT_B: begin
          if (trigger) begin
            next_s.shot = ospwc_pkg::OSPWC_SHOT_WAIT_A;
          end else if (match_b) begin
            toggle      = 1'b1;
            next_s.shot = ospwc_pkg::OSPWC_SHOT_IDLE;
          end
        end
        default: next_s.shot = ospwc_pkg::OSPWC_SHOT_IDLE;
      endcase
    end else begin
      next_s.shot = ospwc_pkg::OSPWC_SHOT_IDLE;
      toggle = (match_a && s.out_ctrl[`OSPWC_INV_A_BIT])
               ^ (match_b && s.out_ctrl[`OSPWC_INV_B_BIT])
               ^ (a_valid && s.edge_toggle && cap_a && cap_b);
    end
    if (toggle) begin
      next_s.out_level = ~s.out_level;
    end

    // Register writes
    irq_clr = 3'h0;
    if (wr_en) begin
      unique case (addr)
        `OSPWC_OFF_MODE_CTRL: begin
          next_s.mode        = ospwc_pkg::ospwc_mode_t'(wr_data[`OSPWC_MODE_LSB +: 2]);
          next_s.edge_toggle = wr_data[`OSPWC_EDGE_TOGGLE_BIT];
          // Software may only clear the flag
          next_s.wrap_flag   = s.wrap_flag & wr_data[`OSPWC_WRAP_FLAG_BIT];
        end
        `OSPWC_OFF_CAPTURE_CTRL: next_s.cap_ctrl = wr_data[2:0];
        `OSPWC_OFF_OUTPUT_CTRL: begin
          next_s.out_ctrl = wr_data[5:0];
          // Static level control only while stopped; both set is ignored
          if (!running) begin
            if (wr_data[`OSPWC_LEVEL_SET_BIT] && !wr_data[`OSPWC_LEVEL_CLR_BIT]) begin
              next_s.out_level = 1'b1;
            end else if (wr_data[`OSPWC_LEVEL_CLR_BIT]
                         && !wr_data[`OSPWC_LEVEL_SET_BIT]) begin
              next_s.out_level = 1'b0;
            end
          end
        end
        `OSPWC_OFF_PRESCALE:   next_s.prescale = wr_data[1:0];
        `OSPWC_OFF_EDGE_SEL:   next_s.edge_sel = wr_data[3:0];
        `OSPWC_OFF_COMPARE_A:  next_s.cmp_a    = wr_data;
        `OSPWC_OFF_COMPARE_B:  next_s.cmp_b    = wr_data;
        `OSPWC_OFF_IRQ_STATUS: irq_clr         = wr_data[2:0];
        `OSPWC_OFF_IRQ_MASK:   next_s.irq_mask = wr_data[2:0];
        default: ;
      endcase
    end

    // Hardware captures override a software write to the same register
    if (cap_a && (s.cap_ctrl[`OSPWC_CAP_A_SRC_BIT] ? a_opposite : b_valid)) begin
      next_s.cmp_a = s.up_counter;
    end
    if (cap_b && a_valid) begin
      next_s.cmp_b = s.up_counter;
    end

    // Set wins over a clear in the same cycle
    if (wrap) begin
      next_s.wrap_flag = 1'b1;
    end
    irq_set = 3'h0;
    irq_set[`OSPWC_IRQ_MATCH_A_BIT] = match_a
      || (cap_a && (s.cap_ctrl[`OSPWC_CAP_A_SRC_BIT] ? a_opposite : b_valid));
    irq_set[`OSPWC_IRQ_MATCH_B_BIT] = match_b || (cap_b && a_valid);
    irq_set[`OSPWC_IRQ_WRAP_BIT]    = wrap;
    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
    next_s.irq        = |(next_s.irq_status & next_s.irq_mask);

    next_s.timer_out = next_s.out_level & next_s.out_ctrl[`OSPWC_OUT_EN_BIT];

    // Read data stand for the cycle after the strobe only
    rd_word = 16'h0000;
    unique case (addr)
      `OSPWC_OFF_MODE_CTRL:    rd_word = {12'h000, s.mode, s.edge_toggle, s.wrap_flag};
      `OSPWC_OFF_CAPTURE_CTRL: rd_word = {13'h0000, s.cap_ctrl};
      `OSPWC_OFF_OUTPUT_CTRL:  rd_word = {10'h000, s.out_ctrl};
      `OSPWC_OFF_PRESCALE:     rd_word = {14'h0000, s.prescale};
      `OSPWC_OFF_EDGE_SEL:     rd_word = {12'h000, s.edge_sel};
      `OSPWC_OFF_COMPARE_A:    rd_word = s.cmp_a;
      `OSPWC_OFF_COMPARE_B:    rd_word = s.cmp_b;
      `OSPWC_OFF_COUNTER:      rd_word = s.up_counter;
      `OSPWC_OFF_IRQ_STATUS:   rd_word = {13'h0000, s.irq_status};
      `OSPWC_OFF_IRQ_MASK:     rd_word = {13'h0000, s.irq_mask};
      default:                 rd_word = 16'h0000;
    endcase
    next_s.rd_data = rd_en ? rd_word : 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s      <= '0;
      s.shot <= ospwc_pkg::OSPWC_SHOT_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data       = s.rd_data;
  assign timer_out_pin = s.timer_out;
  assign irq           = s.irq;

endmodule // ospwc_timer

// ### ospwc_consts.svh
`ifndef OSPWC_CONSTS_SVH
`define OSPWC_CONSTS_SVH

// Register byte offsets
`define OSPWC_OFF_MODE_CTRL    8'h00
`define OSPWC_OFF_CAPTURE_CTRL 8'h04
`define OSPWC_OFF_OUTPUT_CTRL  8'h08
`define OSPWC_OFF_PRESCALE     8'h0c
`define OSPWC_OFF_EDGE_SEL     8'h10
`define OSPWC_OFF_COMPARE_A    8'h14
`define OSPWC_OFF_COMPARE_B    8'h18
`define OSPWC_OFF_COUNTER      8'h1c
`define OSPWC_OFF_IRQ_STATUS   8'h20
`define OSPWC_OFF_IRQ_MASK     8'h24

// timer_mode_ctrl fields
`define OSPWC_MODE_LSB         2
`define OSPWC_EDGE_TOGGLE_BIT  1
`define OSPWC_WRAP_FLAG_BIT    0

// capture_ctrl_reg fields
`define OSPWC_CAP_A_EN_BIT     0
`define OSPWC_CAP_A_SRC_BIT    1
`define OSPWC_CAP_B_EN_BIT     2

// output_ctrl_reg fields
`define OSPWC_OUT_EN_BIT       0
`define OSPWC_INV_A_BIT        1
`define OSPWC_LEVEL_CLR_BIT    2
`define OSPWC_LEVEL_SET_BIT    3
`define OSPWC_INV_B_BIT        4
`define OSPWC_SP_ENABLE_BIT    5
`define OSPWC_SP_TRIGGER_BIT   6

// Interrupt status and mask fields
`define OSPWC_IRQ_MATCH_A_BIT  0
`define OSPWC_IRQ_MATCH_B_BIT  1
`define OSPWC_IRQ_WRAP_BIT     2

// Reset values and limits
`define OSPWC_RESET_WORD       16'h0000
`define OSPWC_COUNT_MAX        16'hffff

`endif

// ### ospwc_pkg.sv
package ospwc_pkg;

  typedef enum logic [1:0] {
    OSPWC_MODE_STOP      = 2'h0,
    OSPWC_MODE_FREE      = 2'h1,
    OSPWC_MODE_EDGE_CLR  = 2'h2,
    OSPWC_MODE_MATCH_CLR = 2'h3
  } ospwc_mode_t;

  typedef enum logic [2:0] {
    OSPWC_SHOT_IDLE   = 3'h1,
    OSPWC_SHOT_WAIT_A = 3'h2,
    OSPWC_SHOT_WAIT_B = 3'h4
  } ospwc_shot_t;

  typedef struct packed {
    ospwc_mode_t mode;
    logic        edge_toggle;
    logic        wrap_flag;
    logic [2:0]  cap_ctrl;
    logic [5:0]  out_ctrl;
    logic [1:0]  prescale;
    logic [3:0]  edge_sel;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] up_counter;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    ospwc_shot_t shot;
    logic        out_level;
    logic        timer_out;
    logic        irq;
    logic [15:0] rd_data;
  } ospwc_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic rise;
    logic fall;
  } ospwc_edge_state_t;

  typedef struct packed {
    logic [2:0] div;
    logic       tick;
  } ospwc_div_state_t;

endpackage

// ### ospwc_edge_detect.sv
module ospwc_edge_detect (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Pin from outside the clock domain
  input  wire logic pin,
  // Edge pulses, one cycle each
  output logic      rise,
  output logic      fall
);

  ospwc_pkg::ospwc_edge_state_t s;
  ospwc_pkg::ospwc_edge_state_t next_s;

  always_comb begin
    next_s       = s;
    next_s.sync1 = pin;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    next_s.rise  = s.sync2 & ~s.prev;
    next_s.fall  = ~s.sync2 & s.prev;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;

endmodule // ospwc_edge_detect

// ### ospwc_prescaler.sv
module ospwc_prescaler (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] prescaler_sel,
  // Count clock, one-cycle pulse
  output logic            tick
);

  ospwc_pkg::ospwc_div_state_t s;
  ospwc_pkg::ospwc_div_state_t next_s;
  logic [2:0]                  limit;

  always_comb begin
    next_s = s;
    limit  = 3'((4'h1 << prescaler_sel) - 4'h1);
    if (!run) begin
      // Held at zero so a start always begins a full count clock period
      next_s.div  = 3'h0;
      next_s.tick = 1'b0;
    end else if (s.div >= limit) begin
      next_s.div  = 3'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div  = 3'(s.div + 3'h1);
      next_s.tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule // ospwc_prescaler

// ### ospwc_timer_props.sv
module ospwc_timer_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] rd_data,
  // Pins and interrupt
  input wire logic        trig_capture_in_a,
  input wire logic        capture_in_b,
  input wire logic        timer_out_pin,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_q;
  logic [2:0] age;
  logic       quiet;
  // A stopped block left alone for a few cycles has no source of events
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= 2'h0;
      age <= 3'h0;
    end else begin
      if (wr_en && addr == 8'h00) begin
        mode_q <= wr_data[3:2];
      end
      age <= wr_en ? 3'h0 : age + {2'h0, age != 3'h7};
    end
  end
  assign quiet = mode_q == 2'h0 && age > 3'h3;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  property p_rd_slot;
    rd_data != 16'h0 |-> $past(rd_en);
  endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("read data outside slot");
  property p_rd_unmapped;
    rd_en && (addr > 8'h24 || addr[1:0] != 2'h0) |=> rd_data == 16'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not 0");
  property p_trig_reads_zero;
    rd_en && addr == 8'h08 |=> !rd_data[6];
  endproperty
  a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger bit read");
  property p_mode_upper;
    rd_en && addr == 8'h00 |=> rd_data[15:4] == 12'h0;
  endproperty
  a_mode_upper: assert property (p_mode_upper) else $error("mode upper bits set");
  property p_mask_off;
    wr_en && addr == 8'h24 && wr_data[2:0] == 3'h0 |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
  property p_out_cause;
    $changed(timer_out_pin) |-> !quiet;
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output moved while idle");
  property p_irq_cause;
    $rose(irq) |-> !quiet;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose while idle");
  property p_reset_clean;
    $fell(reset) |-> !irq && !timer_out_pin && rd_data == 16'h0;
  endproperty
  a_reset_clean: assert property (p_reset_clean) else $error("outputs not clear");
endmodule // ospwc_timer_props

// ### ospwc_pin_src.sv
module ospwc_pin_src (
  // Clock
  input wire logic ref_clk,
  // Timer output seen by the load
  input wire logic timer_out_pin,
  // Pulse sources
  output logic     pin_a,
  output logic     pin_b,
  // Set when a pulse never ended before the next edge was due
  output logic     overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    overrun = 1'b0;
  end
  // Edges land 3 ns after a clock edge, well away from the sampling point
  task automatic drive(input logic to_b, input logic lvl, input int gap);
    int i;
    repeat (gap) @(posedge ref_clk);
    // A retrigger in mid-pulse would restart the sequence
    for (i = 0; i < 99 && !to_b && timer_out_pin === 1'b1; i++) begin
      @(posedge ref_clk);
    end
    if (i == 99) begin
      overrun = 1'b1;
    end
    #3;
    if (to_b) begin
      pin_b = lvl;
    end else begin
      pin_a = lvl;
    end
  endtask
endmodule // ospwc_pin_src

// ### tb_one_shot_and_pulse_width_capture.sv
module tb_one_shot_and_pulse_width_capture;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] v;
    logic [15:0] m;
  } ospwc_note_t;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wr_data = 16'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [15:0] rd_data;
  logic        pin_a;
  logic        pin_b;
  logic        overrun;
  logic        timer_out_pin;
  logic        irq;
  logic        seen = 1'b0;
  logic [15:0] last_rd, va, vb, vc, st;
  ospwc_note_t notes[$];
  ospwc_note_t cur;
  int          miscompares = 0;
  int          n_compared = 0;
  int          j, md, ps, div, m, n, d, p, w, lo;

  ospwc_timer uut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .trig_capture_in_a(pin_a),
    .capture_in_b(pin_b), .timer_out_pin(timer_out_pin), .irq(irq));
  ospwc_pin_src src (.ref_clk(ref_clk), .timer_out_pin(timer_out_pin), .pin_a(pin_a),
    .pin_b(pin_b), .overrun(overrun));

  initial forever #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] dat);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= dat;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] msk);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    notes.push_back('{e, msk});
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rd_val(input logic [7:0] a, output logic [15:0] v);
    rd(a, 16'h0, 16'h0);
    v = last_rd;
  endtask
  task automatic wait_pin(input logic lvl, output int cnt);
    for (cnt = 0; timer_out_pin !== lvl; cnt++) begin
      if (cnt > 300) begin
        miscompares++;
        give_verdict();
      end
      @(posedge ref_clk);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (seen && notes.size() > 0) begin
      cur = notes.pop_front();
      last_rd = rd_data;
      if (cur.m != 16'h0) begin
        chk(rd_data & cur.m, cur.v & cur.m);
      end
    end
    seen = rd_en;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    j = $urandom(74);
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (j = 0; j < 11; j++) begin
      rd(8'(j * 4), 16'h0, 16'hffff);
    end
    // One-shot: stopped mode, software trigger in both modes, pin trigger last
    for (j = 0; j < 5; j++) begin
      md = (j == 0) ? 0 : 1 + j % 2;
      ps = (j == 2 || j == 3) ? 1 : 0;
      div = 1 << ps;
      m = 2 + $urandom % 6;
      n = m + 1 + $urandom % 6;
      wr(8'h00, 16'h0);
      wr(8'h14, 16'(m));
      wr(8'h18, 16'(n));
      wr(8'h0c, 16'(ps));
      wr(8'h10, (j == 4) ? 16'h1 : 16'h2);
      wr(8'h24, 16'h3);
      wr(8'h08, 16'h21);
      wr(8'h00, 16'(md << 2));
      if (j == 4) begin
        src.drive(1'b0, 1'b1, 1);
      end else begin
        wr(8'h08, 16'h61);
      end
      if (md == 0) begin
        repeat ((n + 4) * div) @(posedge ref_clk);
        chk({15'h0, timer_out_pin}, 16'h0);
      end else begin
        wait_pin(1'b1, w);
        chk(16'(w >= (m + 1) * div && w <= (m + 2) * div + 6), 16'h1);
        wait_pin(1'b0, w);
        chk(16'(w), 16'((n - m) * div));
      end
      st = (md == 0) ? 16'h0 : 16'h3;
      wr(8'h24, 16'h0);
      rd(8'h20, st, 16'h3);
      chk({15'h0, irq}, 16'h0);
      wr(8'h24, 16'h3);
      rd(8'h20, st, 16'h3);
      chk({15'h0, irq}, st & 16'h1);
      wr(8'h20, 16'h7);
      rd(8'h20, 16'h0, 16'h3);
    end
    src.drive(1'b0, 1'b0, 1);
    // Pulse generation, starting high
    m = 6 + $urandom % 8;
    n = $urandom % m;
    wr(8'h00, 16'h0);
    wr(8'h0c, 16'h0);
    wr(8'h14, 16'(m));
    wr(8'h18, 16'(n));
    wr(8'h08, 16'h09);
    // Both match inversions on; with neither on, only the edge toggle with both captures enabled moves the level in this mode
    wr(8'h08, 16'h13);
    wr(8'h00, 16'h0c);
    wait_pin(1'b0, w);
    wait_pin(1'b1, lo);
    wait_pin(1'b0, w);
    chk(16'(w), 16'(n + 1));
    chk(16'(w + lo), 16'(m + 1));
    // Capture, free running, two inputs then one input
    wr(8'h00, 16'h0);
    wr(8'h08, 16'h0);
    wr(8'h04, 16'h5);
    wr(8'h10, 16'hf);
    wr(8'h00, 16'h4);
    rd_val(8'h1c, va);
    rd_val(8'h1c, vb);
    chk(vb - va, 16'h3);
    d = 5 + $urandom % 20;
    p = 5 + $urandom % 20;
    src.drive(1'b1, 1'b1, 2);
    src.drive(1'b0, 1'b1, d);
    repeat (4) @(posedge ref_clk);
    rd_val(8'h14, va);
    rd_val(8'h18, vb);
    chk(vb - va, 16'(d));
    wr(8'h04, 16'h7);
    wr(8'h10, 16'hc);
    src.drive(1'b0, 1'b0, 2);
    src.drive(1'b0, 1'b1, d);
    repeat (4) @(posedge ref_clk);
    rd_val(8'h14, va);
    rd_val(8'h18, vb);
    chk(va - vb, 16'(d));
    // Clear on falling edge, then one period that wraps once
    wr(8'h00, 16'h8);
    src.drive(1'b0, 1'b0, 2);
    src.drive(1'b0, 1'b1, d);
    src.drive(1'b0, 1'b0, p);
    repeat (4) @(posedge ref_clk);
    rd_val(8'h14, va);
    rd_val(8'h18, vc);
    chk(vc - va, 16'(p));
    wr(8'h00, 16'h8);
    src.drive(1'b0, 1'b1, 2);
    src.drive(1'b0, 1'b0, 2);
    src.drive(1'b0, 1'b1, d);
    src.drive(1'b0, 1'b0, p + 65536);
    repeat (4) @(posedge ref_clk);
    rd_val(8'h18, vb);
    rd_val(8'h00, va);
    chk(va & 16'h1, 16'h1);
    chk(vb, vc);
    rd(8'h20, 16'h4, 16'h4);
    wr(8'h00, 16'h8);
    rd(8'h00, 16'h8, 16'hf);
    chk({15'h0, overrun}, 16'h0);
    give_verdict();
  end
endmodule // tb_one_shot_and_pulse_width_capture

bind ospwc_timer ospwc_timer_props u_props (.ref_clk(ref_clk), .reset(reset), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .trig_capture_in_a(trig_capture_in_a), .capture_in_b(capture_in_b),
  .timer_out_pin(timer_out_pin), .irq(irq));
